// file: hw/rtc_status_irq.sv
// Status monitor flags, supply sampling and interrupt merge
`timescale 1ns/1ps
// Summary of operation
// (RL1) Power-up reset clears control and adjust registers
// (RL2) Threshold select picks 1.6 V or 1.3 V
// (RL3) Power and low-supply high; osc flag low
// (RL4) Power and low-supply flags accept only 0
// (RL5) After power-up: power flag 1, low 0
// (RL6) Crystal stop clears oscillation-running flag
// (RL7) Power flag set forces config bits to 0
// (RL8) Supply sampled 7.8 ms each second only
// (RL9) Low-supply flag set stops sampling
// (RL10) Host clears low flag after seconds write
// (RL11) Alarm match drives interrupt low
// (RL12) Period select picks pulse or level output
// (RL13) Flags and enables at documented bit positions
// (RL14) Period select zero disables periodic source
// (RL15) Power-on defaults keep interrupt high
// (RL16) Interrupt low while any source low
// (RL17) Host reads flags to find source
// (RL18) Period codes: off, low, 2Hz, 1Hz, levels
// (RL19) Level mode holds low until flag cleared
// (RL20) Alarm flag write 0 releases; 1 ignored
// (RL21) Flags hold until cleared or reset
module rtc_status_irq #(
   parameter int SAMPLE_CYC = rtc_status_pkg::SAMPLE_WIN_CYC,
   parameter int OSC_TIMEOUT = rtc_status_pkg::OSC_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Power detect: pulse when supply rises from zero
   input wire logic power_up_pulse,
   // Register port
   input wire logic reg_wr,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Timebase events from the counters
   input wire logic xtal_tick,
   input wire logic half_sec_tick,
   input wire logic sec_tick,
   input wire logic min_tick,
   input wire logic hour_tick,
   input wire logic month_tick,
   input wire logic week_match,
   input wire logic day_match,
   // Supply comparators
   input wire logic below_1v6,
   input wire logic below_1v3,
   // Outputs
   output logic supply_sample_en,
   output logic [7:0] adjust_reg,
   output logic irq_out_n,
   output logic irq_out_oe
);
   if (SAMPLE_CYC < 1 || OSC_TIMEOUT < 2) begin : g_bad_param
      $error("rtc_status_irq: bad parameter");
   end

   logic [7:0] cfg;
   logic [7:0] flags;
   logic [7:0] next_cfg;
   logic [7:0] next_flags;
   logic pulse_lvl;
   logic next_pulse_lvl;
   logic [31:0] osc_cnt;
   logic [31:0] next_osc_cnt;
   logic [31:0] samp_cnt;
   logic [31:0] next_samp_cnt;
   logic next_sample_en;
   logic next_irq_n;
   logic wr_cfg;
   logic wr_flag;
   logic below;
   logic [7:0] next_rdata;

   typedef enum logic [1:0] {
      SAMP_IDLE = 2'b00,
      SAMP_RUN = 2'b01,
      SAMP_HOLD = 2'b11
   } samp_state_e;
   samp_state_e samp_st;
   samp_state_e next_samp_st;

   function automatic logic period_event(input logic [2:0] sel,
      input logic s, input logic m, input logic h, input logic mo);
      case (sel)
         rtc_status_pkg::PSEL_SEC: period_event = s;
         rtc_status_pkg::PSEL_MIN: period_event = m;
         rtc_status_pkg::PSEL_HOUR: period_event = h;
         rtc_status_pkg::PSEL_MONTH: period_event = mo;
         default: period_event = 1'b0;
      endcase
   endfunction : period_event

   assign wr_cfg = reg_wr && (reg_addr == rtc_status_pkg::CFG_ADDR);
   assign wr_flag = reg_wr && (reg_addr == rtc_status_pkg::FLAG_ADDR);

   rtc_reg_byte #(
      .RESET_VAL(rtc_status_pkg::ADJ_RESET)
   ) u_adjust (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clear(flags[rtc_status_pkg::FLAG_POWER_UP]), // [RL1] [RL7]
      .wr_en(1'b0),
      .wr_data(8'h00),
      .value(adjust_reg)
   );

   // Threshold choice [RL2]
   assign below = flags[rtc_status_pkg::FLAG_THRESH] ? below_1v3 : below_1v6;

   always_comb begin
      next_cfg = cfg;
      next_flags = flags;
      next_pulse_lvl = pulse_lvl;
      next_osc_cnt = osc_cnt;
      if (wr_cfg) begin
         next_cfg = reg_wdata;
      end
      if (wr_flag) begin
         next_flags[rtc_status_pkg::FLAG_THRESH] =
            reg_wdata[rtc_status_pkg::FLAG_THRESH];
         next_flags[rtc_status_pkg::FLAG_CLK_DIS1] =
            reg_wdata[rtc_status_pkg::FLAG_CLK_DIS1];
         next_flags[rtc_status_pkg::FLAG_OSC_RUN] =
            reg_wdata[rtc_status_pkg::FLAG_OSC_RUN]; // [RL4]
         // Write 0 clears, write 1 ignored [RL4] [RL20] [RL19]
         next_flags[rtc_status_pkg::FLAG_POWER_UP] =
            flags[rtc_status_pkg::FLAG_POWER_UP] &
            reg_wdata[rtc_status_pkg::FLAG_POWER_UP];
         next_flags[rtc_status_pkg::FLAG_LOW_SUPPLY] =
            flags[rtc_status_pkg::FLAG_LOW_SUPPLY] &
            reg_wdata[rtc_status_pkg::FLAG_LOW_SUPPLY];
         next_flags[rtc_status_pkg::FLAG_PERIODIC] =
            flags[rtc_status_pkg::FLAG_PERIODIC] &
            reg_wdata[rtc_status_pkg::FLAG_PERIODIC];
         next_flags[rtc_status_pkg::FLAG_WEEK] =
            flags[rtc_status_pkg::FLAG_WEEK] &
            reg_wdata[rtc_status_pkg::FLAG_WEEK];
         next_flags[rtc_status_pkg::FLAG_DAY] =
            flags[rtc_status_pkg::FLAG_DAY] &
            reg_wdata[rtc_status_pkg::FLAG_DAY];
      end
      // Events win over a same-cycle clear [RL11] [RL21]
      if (week_match && cfg[rtc_status_pkg::CFG_WEEK_EN]) begin
         next_flags[rtc_status_pkg::FLAG_WEEK] = 1'b1;
      end
      if (day_match && cfg[rtc_status_pkg::CFG_DAY_EN]) begin
         next_flags[rtc_status_pkg::FLAG_DAY] = 1'b1;
      end
      if (period_event(cfg[2:0], sec_tick, min_tick, hour_tick,
            month_tick)) begin
         next_flags[rtc_status_pkg::FLAG_PERIODIC] = 1'b1; // [RL19]
      end
      if (samp_st == SAMP_RUN && below) begin
         next_flags[rtc_status_pkg::FLAG_LOW_SUPPLY] = 1'b1; // [RL3]
      end
      // Pulse modes: 2Hz toggles on half-second, 1Hz on second, low half aligned [RL18]
      if (cfg[2:0] == rtc_status_pkg::PSEL_2HZ && half_sec_tick) begin
         next_pulse_lvl = ~pulse_lvl;
      end else if (cfg[2:0] == rtc_status_pkg::PSEL_1HZ && sec_tick) begin
         next_pulse_lvl = ~pulse_lvl;
      end else if (cfg[2:1] != 2'b01) begin
         next_pulse_lvl = 1'b0;
      end
      // Crystal halt watchdog [RL6]
      if (xtal_tick) begin
         next_osc_cnt = 32'h0000_0000;
      end else if (osc_cnt < 32'(OSC_TIMEOUT)) begin
         next_osc_cnt = osc_cnt + 32'h0000_0001;
      end else begin
         next_flags[rtc_status_pkg::FLAG_OSC_RUN] = 1'b0; // [RL6]
      end
      // Power-up forcing [RL1] [RL7]
      // Only osc and power flags survive; a written 0 still clears power
      if (flags[rtc_status_pkg::FLAG_POWER_UP]) begin
         next_cfg = rtc_status_pkg::CFG_RESET;
         next_flags = next_flags & 8'h30;
      end
      if (power_up_pulse) begin
         next_cfg = rtc_status_pkg::CFG_RESET;
         next_flags = rtc_status_pkg::FLAG_RESET; // [RL5]
      end
   end

   // Supply sampling window once per second [RL8] [RL9]
   always_comb begin
      next_samp_st = samp_st;
      next_samp_cnt = samp_cnt;
      case (samp_st)
         SAMP_IDLE: begin
            if (sec_tick && !flags[rtc_status_pkg::FLAG_LOW_SUPPLY]) begin
               next_samp_st = SAMP_RUN; // [RL8]
               next_samp_cnt = 32'h0000_0000;
            end
         end
         SAMP_RUN: begin
            if (flags[rtc_status_pkg::FLAG_LOW_SUPPLY]) begin
               next_samp_st = SAMP_HOLD; // [RL9]
            end else if (samp_cnt >= 32'(SAMPLE_CYC - 1)) begin
               next_samp_st = SAMP_IDLE;
            end else begin
               next_samp_cnt = samp_cnt + 32'h0000_0001;
            end
         end
         SAMP_HOLD: begin
            if (!flags[rtc_status_pkg::FLAG_LOW_SUPPLY]) begin
               next_samp_st = SAMP_IDLE; // [RL9]
            end
         end
         default: next_samp_st = SAMP_IDLE;
      endcase
      next_sample_en = (next_samp_st == SAMP_RUN);
   end

   // Merge of active-low sources [RL16] [RL14] [RL15] [RL12]
   always_comb begin
      next_irq_n = 1'b1;
      if (next_flags[rtc_status_pkg::FLAG_WEEK] ||
          next_flags[rtc_status_pkg::FLAG_DAY]) begin
         next_irq_n = 1'b0; // [RL11]
      end
      case (next_cfg[2:0])
         rtc_status_pkg::PSEL_OFF: ;
         rtc_status_pkg::PSEL_LOW: next_irq_n = 1'b0;
         rtc_status_pkg::PSEL_2HZ,
         rtc_status_pkg::PSEL_1HZ: begin
            if (next_pulse_lvl) begin
               next_irq_n = 1'b0;
            end
         end
         default: begin
            if (next_flags[rtc_status_pkg::FLAG_PERIODIC]) begin
               next_irq_n = 1'b0; // [RL19]
            end
         end
      endcase
      next_rdata = 8'h00;
      if (reg_addr == rtc_status_pkg::CFG_ADDR) begin
         next_rdata = next_cfg; // [RL13]
      end else if (reg_addr == rtc_status_pkg::FLAG_ADDR) begin
         next_rdata = next_flags; // [RL13] [RL17]
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= rtc_status_pkg::CFG_RESET;
         flags <= rtc_status_pkg::FLAG_RESET;
         pulse_lvl <= 1'b0;
         osc_cnt <= 32'h0000_0000;
         samp_cnt <= 32'h0000_0000;
         samp_st <= SAMP_IDLE;
         supply_sample_en <= 1'b0;
         irq_out_n <= 1'b1;
         irq_out_oe <= 1'b1;
         reg_rdata <= 8'h00;
      end else begin
         cfg <= next_cfg;
         flags <= next_flags;
         pulse_lvl <= next_pulse_lvl;
         osc_cnt <= next_osc_cnt;
         samp_cnt <= next_samp_cnt;
         samp_st <= next_samp_st;
         supply_sample_en <= next_sample_en;
         irq_out_n <= next_irq_n;
         irq_out_oe <= next_irq_n; // open drain: oe low drives low
         reg_rdata <= next_rdata;
      end
   end

   // Assertions
   weekly_alarm_irq_a: assert property (@(posedge core_clk) // [RL11]
      disable iff (!rst_b)
      (week_match && cfg[rtc_status_pkg::CFG_WEEK_EN] && !power_up_pulse
       && !flags[rtc_status_pkg::FLAG_POWER_UP]) |=> !irq_out_n)
      else $error("weekly alarm did not pull irq low");
   power_flag_clear_a: assert property (@(posedge core_clk) // [RL7]
      disable iff (!rst_b)
      flags[rtc_status_pkg::FLAG_POWER_UP] && !power_up_pulse
      |=> cfg == 8'h00 && flags[rtc_status_pkg::FLAG_DAY] == 1'b0)
      else $error("power flag did not force bits");
   power_flag_sticky_a: assert property (@(posedge core_clk) // [RL4]
      disable iff (!rst_b)
      flags[rtc_status_pkg::FLAG_POWER_UP] && !wr_flag
      |=> flags[rtc_status_pkg::FLAG_POWER_UP])
      else $error("power flag lost without write");
   level_hold_a: assert property (@(posedge core_clk) // [RL19]
      disable iff (!rst_b)
      flags[rtc_status_pkg::FLAG_PERIODIC] && cfg[2] && !wr_flag
      && !wr_cfg && !flags[rtc_status_pkg::FLAG_POWER_UP]
      && !power_up_pulse |=> !irq_out_n)
      else $error("level irq released early");
   periodic_off_a: assert property (@(posedge core_clk) // [RL15]
      disable iff (!rst_b)
      cfg == 8'h00 && !wr_cfg && !power_up_pulse
      && !(next_flags[1] || next_flags[0]) |=> irq_out_n)
      else $error("irq low with all sources off");
   fixed_low_a: assert property (@(posedge core_clk) // [RL18]
      disable iff (!rst_b)
      cfg[2:0] == rtc_status_pkg::PSEL_LOW && !wr_cfg
      && !flags[rtc_status_pkg::FLAG_POWER_UP] && !power_up_pulse
      |=> !irq_out_n)
      else $error("fixed low mode not low");
   sample_stop_a: assert property (@(posedge core_clk) // [RL9]
      disable iff (!rst_b)
      flags[rtc_status_pkg::FLAG_LOW_SUPPLY] |=> !supply_sample_en)
      else $error("sampling while low flag set");
   sample_win_a: assert property (@(posedge core_clk) // [RL8]
      disable iff (!rst_b)
      $rose(supply_sample_en) |-> $past(sec_tick))
      else $error("sample window misaligned");
endmodule : rtc_status_irq

// file: hw/rtc_status_pkg.sv
// Package: register map, field positions and timing constants
package rtc_status_pkg;
   localparam logic [3:0] CFG_ADDR = 4'hE;
   localparam logic [3:0] FLAG_ADDR = 4'hF;
   localparam int CFG_WEEK_EN = 7;
   localparam int CFG_DAY_EN = 6;
   localparam int CFG_CLK_DIS2 = 4;
   localparam int FLAG_LOW_SUPPLY = 6;
   localparam int FLAG_OSC_RUN = 5;
   localparam int FLAG_POWER_UP = 4;
   localparam int FLAG_CLK_DIS1 = 3;
   localparam int FLAG_PERIODIC = 2;
   localparam int FLAG_WEEK = 1;
   localparam int FLAG_DAY = 0;
   localparam int FLAG_THRESH = 7;
   localparam logic [2:0] PSEL_OFF = 3'h0;
   localparam logic [2:0] PSEL_LOW = 3'h1;
   localparam logic [2:0] PSEL_2HZ = 3'h2;
   localparam logic [2:0] PSEL_1HZ = 3'h3;
   localparam logic [2:0] PSEL_SEC = 3'h4;
   localparam logic [2:0] PSEL_MIN = 3'h5;
   localparam logic [2:0] PSEL_HOUR = 3'h6;
   localparam logic [2:0] PSEL_MONTH = 3'h7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h10;
   localparam logic [7:0] ADJ_RESET = 8'h00;
   localparam int CLK_MHZ = 200;
   localparam int SAMPLE_WIN_US = 7800;
   localparam int SAMPLE_WIN_CYC = SAMPLE_WIN_US * CLK_MHZ;
   localparam int OSC_TIMEOUT_CYC = 64;
endpackage : rtc_status_pkg

// file: hw/rtc_reg_byte.sv
// Small register byte store with registered read data
`timescale 1ns/1ps
module rtc_reg_byte #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Access
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);
   logic [7:0] next_value;

   always_comb begin
      next_value = value;
      if (clear) begin
         next_value = RESET_VAL;
      end else if (wr_en) begin
         next_value = wr_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         value <= 8'h00;
      end else begin
         value <= next_value;
      end
   end
endmodule : rtc_reg_byte

// file: verification/host_irq_model.sv
// Host side of the open-drain interrupt line
`timescale 1ns/1ps
module host_irq_model (
   // Clock
   input wire logic core_clk,
   // Interrupt pin
   input wire logic irq_out_n,
   input wire logic irq_out_oe,
   // Resolved line and arrivals seen
   output logic irq_line,
   output int irq_falls
);
   logic last = 1'b1;
   // Pull-up holds the line high when released
   assign irq_line = irq_out_oe ? 1'b1 : irq_out_n;
   initial irq_falls = 0;
   // Each falling edge is a cue to read the flags
   always @(posedge core_clk) begin
      if (last && !irq_line) irq_falls++;
      last <= irq_line;
   end
endmodule : host_irq_model

// file: verification/rtc_status_and_interrupt_out_test.sv
// Self-checking bench for status flags and interrupt merge
`timescale 1ns/1ps
module rtc_status_and_interrupt_out_test;
   typedef struct {
      logic [2:0] code;
      int ev;
      logic irq;
      int fl;
   } row_s;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_up_pulse = 1'b0;
   logic reg_wr = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [6:0] ev = 7'h00;
   logic xtal_tick = 1'b0;
   logic xtal_on = 1'b1;
   logic below_1v6 = 1'b0;
   logic below_1v3 = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] adjust_reg;
   logic supply_sample_en;
   logic irq_out_n;
   logic irq_out_oe;
   logic irq_line;
   logic [7:0] d;
   int irq_falls;
   int f0 = 0;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   // Code, event index, pin after event, flag 0/1 or 2 to skip
   row_s rows [9] = '{
      '{3'h0, 1, 1'b1, 0}, '{3'h1, 7, 1'b0, 2}, '{3'h2, 0, 1'b0, 2},
      '{3'h3, 1, 1'b0, 2}, '{3'h4, 1, 1'b0, 1}, '{3'h5, 2, 1'b0, 1},
      '{3'h6, 3, 1'b0, 1}, '{3'h7, 4, 1'b0, 1}, '{3'h6, 2, 1'b1, 0}};

   rtc_status_irq #(.SAMPLE_CYC(20)) uut (
      .core_clk(core_clk), .rst_b(rst_b),
      .power_up_pulse(power_up_pulse), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .xtal_tick(xtal_tick), .half_sec_tick(ev[0]), .sec_tick(ev[1]),
      .min_tick(ev[2]), .hour_tick(ev[3]), .month_tick(ev[4]),
      .week_match(ev[5]), .day_match(ev[6]), .below_1v6(below_1v6),
      .below_1v3(below_1v3), .supply_sample_en(supply_sample_en),
      .adjust_reg(adjust_reg), .irq_out_n(irq_out_n),
      .irq_out_oe(irq_out_oe));
   host_irq_model host (
      .core_clk(core_clk), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
      .irq_line(irq_line), .irq_falls(irq_falls));

   always #2.5 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      xtal_tick <= xtal_on && (cyc % 4 == 0);
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk8
   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk1
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      reg_addr = a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk8(d, e);
   endtask : rdchk
   task automatic pulse(input int i);
      if (i < 7) ev[i] = 1'b1;
      @(negedge core_clk);
      ev = 7'h00;
   endtask : pulse
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : idle
   task automatic stop_test;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test

   initial begin
      idle(16);
      rst_b = 1'b1;
      rdchk(4'hF, 8'h10);
      wr(4'hE, 8'hC3);
      rdchk(4'hE, 8'h00);
      wr(4'hF, 8'h20);
      wr(4'hF, 8'h70);
      rdchk(4'hF, 8'h20);
      foreach (rows[i]) begin
         wr(4'hE, {5'h00, rows[i].code});
         pulse(rows[i].ev);
         idle(4);
         chk1(irq_line, rows[i].irq);
         rd(4'hF);
         if (rows[i].fl < 2) chk1(d[2], rows[i].fl[0]);
         wr(4'hF, 8'h20);
         idle(2);
         if (rows[i].fl == 1) chk1(irq_line, 1'b1);
         wr(4'hE, 8'h00);
         idle(2);
         chk1(irq_line, 1'b1);
      end
      // Alarms: disabled match ignored, then both sources merged
      pulse(6);
      rdchk(4'hF, 8'h20);
      wr(4'hE, 8'hC0);
      f0 = irq_falls;
      pulse(6);
      pulse(5);
      idle(2);
      rdchk(4'hF, 8'h23);
      chk8(8'(irq_falls - f0), 8'h01);
      wr(4'hF, 8'h32);
      rdchk(4'hF, 8'h22);
      chk1(irq_line, 1'b0);
      wr(4'hF, 8'h20);
      idle(2);
      chk1(irq_line, 1'b1);
      rdchk(4'hE, 8'hC0);
      wr(4'hE, 8'h00);
      // Supply sampling window, stop after detect, threshold select
      below_1v6 = 1'b1;
      pulse(1);
      idle(1);
      chk1(supply_sample_en, 1'b1);
      idle(25);
      chk1(supply_sample_en, 1'b0);
      rdchk(4'hF, 8'h60);
      pulse(1);
      idle(2);
      chk1(supply_sample_en, 1'b0);
      wr(4'hF, 8'hA0);
      idle(1);
      pulse(1);
      idle(1);
      chk1(supply_sample_en, 1'b1);
      idle(25);
      rdchk(4'hF, 8'hA0);
      below_1v3 = 1'b1;
      pulse(1);
      idle(25);
      rdchk(4'hF, 8'hE0);
      below_1v6 = 1'b0;
      below_1v3 = 1'b0;
      wr(4'hF, 8'h20);
      // Crystal stop
      xtal_on = 1'b0;
      idle(80);
      rdchk(4'hF, 8'h00);
      xtal_on = 1'b1;
      idle(5);
      wr(4'hF, 8'h20);
      rdchk(4'hF, 8'h20);
      // Supply rise from zero in mid-run
      wr(4'hE, 8'hC1);
      power_up_pulse = 1'b1;
      idle(1);
      power_up_pulse = 1'b0;
      idle(1);
      rd(4'hF);
      chk8(d & 8'hDF, 8'h10);
      rdchk(4'hE, 8'h00);
      chk8(adjust_reg, 8'h00);
      chk1(irq_line, 1'b1);
      stop_test();
   end
endmodule : rtc_status_and_interrupt_out_test
